// >>> compact_timer.sv
// Compact 10-bit timer: control registers, counter, two comparators,
// compare-match, PWM and timer modes, true and inverted output pins.
// Assumes a byte register port with one-cycle read and write strobes.
// Operation
// - Ten-bit up-counter advancing on selected clock
// - P compares bits 9..7; A all bits
// - Counter cleared by counter_on rise, auto clear or overflow
// - Auto clear on overflow or match, flag
// - Pause holds count, resume from held value
// - clock_select picks one of eight codes; 100 and 101 both select the sub clock
// - Off holds residue; on-rise clears counter
// - On-rise forces pin to initial level
// - P period is value times 128, zero 1024
// - Zero period lets counter wrap by overflow
// - mode_select picks compare, PWM or timer
// - Compare mode: A match low, high, toggle
// - PWM: inactive, active, or waveform output
// - Matching requested level leaves pin unchanged
// - initial_level: start level or PWM polarity
// - output_invert inverts the timer output pin
// - duty_period_swap exchanges period and duty roles
// - clear_select picks A or P/overflow clear
// - Second pin is always the complement
// - Low bytes pass through eight-bit buffer
// - clear_select high suppresses the P flag outside PWM mode
// - Duty at or above period is 100%
module compact_timer (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Register port
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       write_i,
  input  wire logic       read_i,
  output logic      [7:0] rdata_o,
  // Clock sources
  input  wire logic       high_clock_en_i,
  input  wire logic       sub_clock_en_i,
  input  wire logic       ext_clock_pin_i,
  // Pins and flags
  output logic            timer_out_pin_o,
  output logic            timer_out_inv_pin_o,
  output logic            compare_a_flag_o,
  output logic            compare_p_flag_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [9:0] count;
    logic [9:0] cmp_a;
    logic [7:0] low_buf;
    logic       on_last;
    logic       pin;
    logic       flag_a;
    logic       flag_p;
  } timer_state_t;

  timer_state_t s_q;
  timer_state_t s_d;

  // Field views
  logic       pause;
  logic [2:0] clk_sel;
  logic       on;
  logic [2:0] period;
  compact_timer_pkg::mode_t mode;
  logic [1:0] action;
  logic       init_level;
  logic       invert;
  logic       swap;
  logic       clear_sel;
  logic       tick;
  logic       on_rise;
  logic       match_a;
  logic       match_p;
  logic       overflow;
  logic       clear_now;
  logic [9:0] duty_val;
  logic [10:0] period_len;
  logic       pwm_active;
  logic       raw_pin;
  logic       rd_hit;
  logic [7:0] rd_mux;
  logic [7:0] rd_q;

  assign pause      = s_q.ctrl0[compact_timer_pkg::PAUSE_BIT];
  assign clk_sel    = s_q.ctrl0[compact_timer_pkg::CLK_SEL_MSB:compact_timer_pkg::CLK_SEL_LSB];
  assign on         = s_q.ctrl0[compact_timer_pkg::ON_BIT];
  assign period     = s_q.ctrl0[compact_timer_pkg::PERIOD_MSB:compact_timer_pkg::PERIOD_LSB];
  assign mode       = compact_timer_pkg::mode_t'(
                      s_q.ctrl1[compact_timer_pkg::MODE_MSB:compact_timer_pkg::MODE_LSB]);
  assign action     = s_q.ctrl1[compact_timer_pkg::ACTION_MSB:compact_timer_pkg::ACTION_LSB];
  assign init_level = s_q.ctrl1[compact_timer_pkg::INIT_LEVEL_BIT];
  assign invert     = s_q.ctrl1[compact_timer_pkg::INVERT_BIT];
  assign swap       = s_q.ctrl1[compact_timer_pkg::SWAP_BIT];
  assign clear_sel  = s_q.ctrl1[compact_timer_pkg::CLEAR_SEL_BIT];

  // ==========================================================
  // Counter clock source
  compact_timer_tick u_tick (
    .clock_i         (clock_i),
    .rst_n_i         (rst_n_i),
    .clock_select_i  (clk_sel),
    .high_clock_en_i (high_clock_en_i),
    .sub_clock_en_i  (sub_clock_en_i),
    .ext_clock_pin_i (ext_clock_pin_i),
    .tick_o          (tick)
  );

  // ==========================================================
  // Comparators, evaluated on the count about to be reached
  function automatic logic coarse_hit(input logic [9:0] cnt, input logic [2:0] val);
    coarse_hit = (val != 3'h0) && (cnt[9:7] == val) && (cnt[6:0] == 7'h00);
  endfunction

  logic [9:0] next_count;
  logic       advance;
  // No advance in the on-rise cycle: the residual count must not match
  assign advance    = on && s_q.on_last && !pause && tick;
  assign next_count = s_q.count + 10'h001;
  assign match_a    = advance && (next_count == s_q.cmp_a) && (s_q.cmp_a != 10'h000);
  assign match_p    = advance && coarse_hit(next_count, period);
  assign overflow   = advance && (s_q.count == compact_timer_pkg::COUNT_MAX);
  assign on_rise    = on && !s_q.on_last;

  // Clear source: PWM uses the period register (compare A when swapped), else clear_select
  always_comb
  begin
    if (mode == compact_timer_pkg::MODE_PWM)
    begin
      clear_now = swap ? match_a : match_p;
    end
    else
    begin
      clear_now = clear_sel ? match_a : match_p;
    end
  end

  // PWM duty and period lengths; zero coarse value means full span
  assign period_len = (period == 3'h0) ? compact_timer_pkg::FULL_SPAN
                                       : {1'b0, period, 7'h00};
  assign duty_val   = swap ? period_len[9:0] : s_q.cmp_a;

  // Active phase of the waveform; duty at or above period stays active
  always_comb
  begin
    if (swap)
    begin
      pwm_active = (period_len[10] || ({1'b0, period_len[9:0]} >= {1'b0, s_q.cmp_a}))
                   ? 1'b1 : ({1'b0, s_q.count} < period_len);
    end
    else
    begin
      pwm_active = ({1'b0, duty_val} >= period_len) ? 1'b1
                   : (s_q.count < duty_val);
    end
  end

  // Pin level before polarity inversion
  always_comb
  begin
    case (mode)
      compact_timer_pkg::MODE_PWM:
        case (action)
          2'b00:   raw_pin = !init_level;
          2'b01:   raw_pin = init_level;
          2'b10:   raw_pin = pwm_active ? init_level : !init_level;
          default: raw_pin = s_q.pin;
        endcase
      compact_timer_pkg::MODE_COMPARE:
        raw_pin = s_q.pin;
      default:
        raw_pin = 1'b0;                 // Pin not used in timer mode
    endcase
  end

  // ==========================================================
  // Next state: registers, counter, pin, flags
  always_comb
  begin
    s_d         = s_q;
    s_d.on_last = on;
    s_d.flag_a  = match_a;
    s_d.flag_p  = match_p && (clear_sel == 1'b0 ||
                  mode == compact_timer_pkg::MODE_PWM);

    // Counter: clear on on-rise, auto clear, overflow wrap
    if (on_rise)
    begin
      s_d.count = compact_timer_pkg::COUNT_RST;
    end
    else if (advance)
    begin
      if (clear_now || overflow)
      begin
        s_d.count = compact_timer_pkg::COUNT_RST;
      end
      else
      begin
        s_d.count = next_count;
      end
    end

    // Compare-match pin action; equal level gives no visible change
    if (on_rise)
    begin
      s_d.pin = init_level;
    end
    else if (mode == compact_timer_pkg::MODE_COMPARE && match_a)
    begin
      case (action)
        2'b01:   s_d.pin = 1'b0;
        2'b10:   s_d.pin = 1'b1;
        2'b11:   s_d.pin = !s_q.pin;
        default: s_d.pin = s_q.pin;
      endcase
    end

    // Register writes; count registers are read only
    if (write_i)
    begin
      case (addr_i)
        compact_timer_pkg::REG_CLOCK_PERIOD_CONTROL: s_d.ctrl0 = wdata_i;
        compact_timer_pkg::REG_MODE_OUTPUT_CONTROL:  s_d.ctrl1 = wdata_i;
        compact_timer_pkg::REG_COMPARE_A_LOW:        s_d.low_buf = wdata_i;
        compact_timer_pkg::REG_COMPARE_A_HIGH:
          s_d.cmp_a = {wdata_i[1:0], s_q.low_buf};
        default: ;
      endcase
    end

    // High-byte reads latch the low byte into the shared buffer
    if (read_i)
    begin
      case (addr_i)
        compact_timer_pkg::REG_COUNT_VALUE_HIGH: s_d.low_buf = s_q.count[7:0];
        compact_timer_pkg::REG_COMPARE_A_HIGH:   s_d.low_buf = s_q.cmp_a[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Read mux; low bytes come from the buffer
  assign rd_hit = read_i;
  always_comb
  begin
    case (addr_i)
      compact_timer_pkg::REG_CLOCK_PERIOD_CONTROL: rd_mux = s_q.ctrl0;
      compact_timer_pkg::REG_MODE_OUTPUT_CONTROL:  rd_mux = s_q.ctrl1;
      compact_timer_pkg::REG_COUNT_VALUE_LOW:      rd_mux = s_q.low_buf;
      compact_timer_pkg::REG_COUNT_VALUE_HIGH:     rd_mux = {6'h00, s_q.count[9:8]};
      compact_timer_pkg::REG_COMPARE_A_LOW:        rd_mux = s_q.low_buf;
      compact_timer_pkg::REG_COMPARE_A_HIGH:       rd_mux = {6'h00, s_q.cmp_a[9:8]};
      default:                                     rd_mux = compact_timer_pkg::READ_UNMAPPED;
    endcase
  end

  // Registered state and read data
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      s_q         <= '0;
      rd_q        <= 8'h00;
    end
    else
    begin
      s_q         <= s_d;
      rd_q        <= rd_hit ? rd_mux : 8'h00;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata_o             = rd_q;
  assign timer_out_pin_o     = (mode == compact_timer_pkg::MODE_TIMER) ? 1'b0
                               : (raw_pin ^ invert);
  assign timer_out_inv_pin_o = !timer_out_pin_o;
  assign compare_a_flag_o    = s_q.flag_a;
  assign compare_p_flag_o    = s_q.flag_p;

  // ==========================================================
  // Checks
  sequence on_rise_s;
    !s_q.on_last ##1 s_q.on_last;
  endsequence

  a_on_rise_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    on_rise |=> (s_q.count == 10'h000))
    else $error("counter not cleared on enable");
  a_pause_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (pause && !on_rise) |=> $stable(s_q.count))
    else $error("counter moved while paused");
  a_off_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (!on) |=> $stable(s_q.count))
    else $error("counter moved while off");
  a_init_level: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    on_rise |=> (s_q.pin == $past(init_level)))
    else $error("pin not set to initial level");
  a_inv_pin: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    timer_out_inv_pin_o != timer_out_pin_o)
    else $error("inverted pin not complement");
  a_no_p_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clear_sel && mode != compact_timer_pkg::MODE_PWM) |=> !s_q.flag_p)
    else $error("P flag raised with A clear");
  a_toggle_pin: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (mode == compact_timer_pkg::MODE_COMPARE && action == 2'b11 && match_a && !on_rise)
    |=> (s_q.pin != $past(s_q.pin)))
    else $error("toggle did not toggle");
  a_a_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (mode != compact_timer_pkg::MODE_PWM && clear_sel && match_a && !on_rise)
    |=> (s_q.count == 10'h000) ##0 s_q.flag_a)
    else $error("A match did not clear");
  a_high_commit: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (write_i && addr_i == compact_timer_pkg::REG_COMPARE_A_HIGH)
    |=> (s_q.cmp_a[7:0] == $past(s_q.low_buf)))
    else $error("low byte not committed");
  a_enable_seq: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    on_rise_s |-> (s_q.count == 10'h000))
    else $error("enable sequence left count");

  // Wrap, P clear, timer-mode pin and full duty
  a_overflow_wrap: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (overflow && !on_rise) |=> (s_q.count == 10'h000))
    else $error("count did not wrap at maximum");
  a_p_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (!clear_sel && mode != compact_timer_pkg::MODE_PWM && match_p && !on_rise)
    |=> (s_q.count == 10'h000) ##0 s_q.flag_p)
    else $error("P match did not clear");
  a_timer_pin: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (mode == compact_timer_pkg::MODE_TIMER) |-> !timer_out_pin_o)
    else $error("pin driven in timer mode");
  a_pwm_full: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (mode == compact_timer_pkg::MODE_PWM && action == 2'b10 && !swap && ({1'b0, s_q.cmp_a} >= period_len))
    |-> (timer_out_pin_o == (init_level ^ invert)))
    else $error("full duty not held active");

endmodule

// >>> compact_timer_pkg.sv
// Package for the compact 10-bit timer: register map, field positions,
// reset values, modes and clock source codes.
// Assumes a byte-wide register port with one-cycle strobes.
package compact_timer_pkg;

  // ==========================================================
  // Register indices on the byte port
  localparam logic [2:0] REG_CLOCK_PERIOD_CONTROL = 3'h0;
  localparam logic [2:0] REG_MODE_OUTPUT_CONTROL  = 3'h1;
  localparam logic [2:0] REG_COUNT_VALUE_LOW      = 3'h2;
  localparam logic [2:0] REG_COUNT_VALUE_HIGH     = 3'h3;
  localparam logic [2:0] REG_COMPARE_A_LOW        = 3'h4;
  localparam logic [2:0] REG_COMPARE_A_HIGH       = 3'h5;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CLOCK_PERIOD_CONTROL_RST = 8'h00;
  localparam logic [7:0] MODE_OUTPUT_CONTROL_RST  = 8'h00;
  localparam logic [9:0] COMPARE_A_RST            = 10'h000;
  localparam logic [9:0] COUNT_RST                = 10'h000;
  localparam logic [7:0] READ_UNMAPPED            = 8'h00;

  // ==========================================================
  // Field positions in clock_period_control
  localparam int PAUSE_BIT      = 7;
  localparam int CLK_SEL_MSB    = 6;
  localparam int CLK_SEL_LSB    = 4;
  localparam int ON_BIT         = 3;
  localparam int PERIOD_MSB     = 2;
  localparam int PERIOD_LSB     = 0;

  // Field positions in mode_output_control
  localparam int MODE_MSB       = 7;
  localparam int MODE_LSB       = 6;
  localparam int ACTION_MSB     = 5;
  localparam int ACTION_LSB     = 4;
  localparam int INIT_LEVEL_BIT = 3;
  localparam int INVERT_BIT     = 2;
  localparam int SWAP_BIT       = 1;
  localparam int CLEAR_SEL_BIT  = 0;

  // ==========================================================
  // Counter geometry
  localparam int          COUNT_W    = 10;
  localparam int          PERIOD_W   = 3;
  localparam logic [9:0]  COUNT_MAX  = 10'h3FF;
  localparam logic [10:0] FULL_SPAN  = 11'h400;  // Period for coarse value zero

  // Prescaler divide counts (DIV_4 in system clock ticks, DIV_16 and DIV_64 in high clock enables)
  localparam logic [5:0]  DIV_4      = 6'h03;
  localparam logic [5:0]  DIV_16     = 6'h0F;
  localparam logic [5:0]  DIV_64     = 6'h3F;

  // ==========================================================
  // Operating modes
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_UNDEF   = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_TIMER   = 2'b11
  } mode_t;

  // Counter clock sources
  typedef enum logic [2:0] {
    CLK_SYS_DIV4  = 3'b000,
    CLK_SYS       = 3'b001,
    CLK_HIGH_D16  = 3'b010,
    CLK_HIGH_D64  = 3'b011,
    CLK_SUB_A     = 3'b100,
    CLK_SUB_B     = 3'b101,
    CLK_EXT_RISE  = 3'b110,
    CLK_EXT_FALL  = 3'b111
  } clk_src_t;

endpackage

// >>> compact_timer_tick.sv
// Counter tick generator: turns the selected clock source into a
// one-cycle advance pulse in the system clock domain.
// Assumes high_clock and sub_clock arrive as synchronous enables.
module compact_timer_tick (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Source selection
  input  wire logic [2:0] clock_select_i,
  input  wire logic       high_clock_en_i,
  input  wire logic       sub_clock_en_i,
  input  wire logic       ext_clock_pin_i,
  // Advance pulse
  output logic            tick_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0] sys_div;
    logic [5:0] high_div;
    logic       ext_meta;
    logic       ext_sync;
    logic       ext_last;
  } tick_state_t;

  tick_state_t s_q;
  tick_state_t s_d;

  // ==========================================================
  // Prescalers and edge detection
  always_comb
  begin
    s_d          = s_q;
    s_d.sys_div  = s_q.sys_div + 2'h1;
    if (high_clock_en_i)
    begin
      s_d.high_div = s_q.high_div + 6'h01;
    end
    s_d.ext_meta = ext_clock_pin_i;
    s_d.ext_sync = s_q.ext_meta;
    s_d.ext_last = s_q.ext_sync;
  end

  // Source selection onto the advance pulse
  always_comb
  begin
    case (compact_timer_pkg::clk_src_t'(clock_select_i))
      compact_timer_pkg::CLK_SYS_DIV4:
        tick_o = (s_q.sys_div == compact_timer_pkg::DIV_4[1:0]);
      compact_timer_pkg::CLK_SYS:
        tick_o = 1'b1;
      compact_timer_pkg::CLK_HIGH_D16:
        tick_o = high_clock_en_i && (s_q.high_div[3:0] == compact_timer_pkg::DIV_16[3:0]);
      compact_timer_pkg::CLK_HIGH_D64:
        tick_o = high_clock_en_i && (s_q.high_div == compact_timer_pkg::DIV_64);
      compact_timer_pkg::CLK_SUB_A,
      compact_timer_pkg::CLK_SUB_B:
        tick_o = sub_clock_en_i;
      compact_timer_pkg::CLK_EXT_RISE:
        tick_o = s_q.ext_sync && !s_q.ext_last;
      compact_timer_pkg::CLK_EXT_FALL:
        tick_o = !s_q.ext_sync && s_q.ext_last;
      default:
        tick_o = 1'b0;
    endcase
  end

  // Register the state
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Rising edge source pulses exactly when the sync stage rises
  a_ext_rise_tick: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (clock_select_i == 3'b110 && $rose(s_q.ext_sync)) |-> tick_o)
    else $error("external rising edge gave no tick");

endmodule

// >>> compact_timer_tb_top.sv
// Self-checking testbench for the compact 10-bit timer.
// Assumes the byte register port of the design, a 200 MHz system clock
// and the register indices 0..5 in table order.
module compact_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals
  logic       clock_i = 1'b0;
  logic       rst_n_i;
  logic [2:0] addr_i;
  logic [7:0] wdata_i;
  logic       write_i;
  logic       read_i;
  logic [7:0] rdata_o;
  logic       high_clock_en_i;
  logic       sub_clock_en_i;
  logic       ext_clock_pin_i;
  logic       timer_out_pin_o;
  logic       timer_out_inv_pin_o;
  logic       compare_a_flag_o;
  logic       compare_p_flag_o;
  logic [2:0] div_q = 3'h0;
  int         n_errors = 0;
  int         checked = 0;

  compact_timer DUT (
    .clock_i            (clock_i),
    .rst_n_i            (rst_n_i),
    .addr_i             (addr_i),
    .wdata_i            (wdata_i),
    .write_i            (write_i),
    .read_i             (read_i),
    .rdata_o            (rdata_o),
    .high_clock_en_i    (high_clock_en_i),
    .sub_clock_en_i     (sub_clock_en_i),
    .ext_clock_pin_i    (ext_clock_pin_i),
    .timer_out_pin_o    (timer_out_pin_o),
    .timer_out_inv_pin_o(timer_out_inv_pin_o),
    .compare_a_flag_o   (compare_a_flag_o),
    .compare_p_flag_o   (compare_p_flag_o)
  );

  // ==========================================================
  // Clock and free-running sources
  always #2.5 clock_i = ~clock_i;

  // Sub clock every other cycle, external pin period of 8 cycles
  always @(posedge clock_i)
    div_q <= div_q + 3'h1;
  assign sub_clock_en_i  = div_q[0];
  assign ext_clock_pin_i = div_q[2];
  assign high_clock_en_i = 1'b1;

  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    write_i <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clock_i);
    write_i <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock_i);
    read_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    read_i <= 1'b0;
    @(negedge clock_i);
    d = rdata_o;
  endtask

  // High byte first so the low byte is latched in the same instant
  task automatic rd_count(output logic [9:0] c);
    logic [7:0] h;
    logic [7:0] l;
    rd(3'h3, h);
    rd(3'h2, l);
    c = {h[1:0], l};
  endtask

  // Stop first: mode and pin action only change while off
  task automatic setup(input logic [7:0] c0, input logic [7:0] c1, input logic [9:0] cmp);
    wr(3'h0, c0 & 8'hF7);
    wr(3'h1, c1);
    wr(3'h4, cmp[7:0]);
    wr(3'h5, {6'h00, cmp[9:8]});
    wr(3'h0, c0);
  endtask

  // Cycles until the chosen flag is next seen high
  task automatic wait_flag(input bit use_p, output logic [15:0] n);
    int i;
    i = 0;
    do
    begin
      @(negedge clock_i);
      i++;
    end
    while (((use_p ? compare_p_flag_o : compare_a_flag_o) !== 1'b1) && i < 3000);
    n = 16'(i);
  endtask

  task automatic gap(input bit use_p, output logic [15:0] n);
    wait_flag(use_p, n);
    wait_flag(use_p, n);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [7:0] d;
    rd(3'h0, d); check("ctrl0 reset", d, 16'h00);
    rd(3'h1, d); check("ctrl1 reset", d, 16'h00);
    rd(3'h5, d); check("cmp hi reset", d, 16'h00);
    rd(3'h6, d); check("unmapped read", d, 16'h00);
    check("inv pin reset", timer_out_inv_pin_o, 16'h1);
    wr(3'h0, 8'h77);
    rd(3'h0, d); check("ctrl0 rw", d, 16'h77);
    wr(3'h1, 8'hA5);
    rd(3'h1, d); check("ctrl1 rw", d, 16'hA5);
    wr(3'h4, 8'h5A);
    wr(3'h5, 8'hFE);
    wr(3'h2, 8'hFF);
    rd(3'h5, d); check("cmp hi", d, 16'h02);
    rd(3'h4, d); check("cmp lo", d, 16'h5A);
    rd(3'h3, d); check("count hi ro", d, 16'h00);
    rd(3'h2, d); check("count lo ro", d, 16'h00);
    wr(3'h1, 8'h00);
  endtask

  // Interval of compare A with value 3 on each clock source
  task automatic t_clock();
    logic [15:0] n;
    logic [15:0] exp [8] = '{16'd12, 16'd3, 16'd48, 16'd192, 16'd6, 16'd6, 16'd24, 16'd24};
    for (int k = 0; k < 8; k++)
    begin
      setup({1'b0, 3'(k), 1'b1, 3'h0}, 8'h01, 10'h003);
      gap(1'b0, n);
      check("clock source interval", n, exp[k]);
    end
  endtask

  // Pin action on A match, both initial levels, with inversion on level 1
  task automatic t_actions();
    logic [15:0] n;
    logic        lv;
    for (int k = 0; k < 8; k++)
    begin
      setup(8'h18, {2'b00, 2'(k), k[2], k[2], 2'b01}, 10'h008);
      // Pin takes the initial level one cycle after the on-rise
      repeat (2) @(negedge clock_i);
      check("pin initial", timer_out_pin_o, 16'(k[2] ^ k[2]));
      lv = (k[1:0] == 2'd0) ? k[2] : (k[1:0] == 2'd1) ? 1'b0 : (k[1:0] == 2'd2) ? 1'b1 : ~k[2];
      wait_flag(1'b0, n);
      repeat (2) @(negedge clock_i);
      check("pin after match", timer_out_pin_o, 16'(lv ^ k[2]));
      check("inv pin", timer_out_inv_pin_o, 16'(!(lv ^ k[2])));
      lv = (k[1:0] == 2'd3) ? ~lv : lv;
      wait_flag(1'b0, n);
      repeat (2) @(negedge clock_i);
      check("pin second match", timer_out_pin_o, 16'(lv ^ k[2]));
    end
  endtask

  task automatic t_period();
    logic [15:0] n;
    setup(8'h19, 8'h00, 10'd200);
    gap(1'b1, n); check("P period 128", n, 16'd128);
    setup(8'h1D, 8'h00, 10'd200);
    gap(1'b1, n); check("P period 640", n, 16'd640);
    setup(8'h18, 8'h00, 10'd1000);
    gap(1'b0, n); check("overflow wrap", n, 16'd1024);
    setup(8'h19, 8'h01, 10'd200);
    gap(1'b0, n); check("A clear period", n, 16'd200);
    wait_flag(1'b1, n); check("no P flag", n, 16'd3000);
    setup(8'h19, 8'hCC, 10'd200);
    gap(1'b1, n); check("timer mode P period", n, 16'd128);
    check("timer mode pin", timer_out_pin_o, 16'h0);
    check("timer mode inv pin", timer_out_inv_pin_o, 16'h1);
  endtask

  task automatic t_pause_on();
    logic [9:0] a;
    logic [9:0] b;
    setup(8'h18, 8'h01, 10'h000);
    repeat (20) @(posedge clock_i);
    wr(3'h0, 8'h98);
    rd_count(a);
    repeat (20) @(posedge clock_i);
    rd_count(b); check("pause holds", b, 16'(a));
    wr(3'h0, 8'h18);
    repeat (10) @(posedge clock_i);
    rd_count(b); check("resume counts", 16'(b > a), 16'h1);
    wr(3'h0, 8'h10);
    rd_count(a);
    repeat (10) @(posedge clock_i);
    rd_count(b); check("off holds residue", b, 16'(a));
    wr(3'h1, 8'h09);
    wr(3'h0, 8'h98);
    rd_count(a); check("on rise clears", a, 16'h000);
    check("pin to initial", timer_out_pin_o, 16'h1);
    check("inv pin low", timer_out_inv_pin_o, 16'h0);
  endtask

  // Active cycles over one full PWM period, phase independent
  task automatic t_pwm();
    logic [15:0] n;
    logic [15:0] hi;
    logic [7:0]  c1 [6] = '{8'hA8, 8'hAC, 8'hA8, 8'hAA, 8'h88, 8'h98};
    logic [9:0]  cm [6] = '{10'd32, 10'd32, 10'd200, 10'd200, 10'd32, 10'd32};
    logic [15:0] ex [6] = '{16'd32, 16'd96, 16'd128, 16'd128, 16'd0, 16'd128};
    for (int k = 0; k < 6; k++)
    begin
      setup(8'h19, c1[k], cm[k]);
      wait_flag(c1[k][1] ? 1'b0 : 1'b1, n);
      wait_flag(c1[k][1] ? 1'b0 : 1'b1, n);
      hi = 16'h0;
      repeat (c1[k][1] ? 200 : 128)
      begin
        @(negedge clock_i);
        hi = hi + 16'(timer_out_pin_o === 1'b1);
      end
      check("pwm active cycles", hi, ex[k]);
    end
  endtask

  // ==========================================================
  // Closing
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog well above the roughly 11000 cycles the scenarios take
  initial
  begin
    repeat (80000) @(posedge clock_i);
    n_errors++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    rst_n_i = 1'b0;
    addr_i  = 3'h0;
    wdata_i = 8'h00;
    write_i = 1'b0;
    read_i  = 1'b0;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    t_regs();
    t_clock();
    t_actions();
    t_period();
    t_pause_on();
    t_pwm();
    report_and_stop();
  end

endmodule
